// [core/ssfm_pkg.sv]
// package: constants and carrier types for start-stop framing and mode control
package ssfm_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] SSFM_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] SSFM_ADDR_BITDIV = 8'h04;
	localparam logic [7:0] SSFM_ADDR_STATUS = 8'h08;

	// ----------------------------------------------------------------
	// code lengths and character-end counts (mid-bit ticks after start)
	// ----------------------------------------------------------------
	localparam logic [1:0] SSFM_CODE_5 = 2'h0;
	localparam logic [1:0] SSFM_CODE_7 = 2'h1;
	localparam logic [1:0] SSFM_CODE_8 = 2'h2;
	localparam logic [3:0] SSFM_END_5  = 4'h6;
	localparam logic [3:0] SSFM_END_7  = 4'h8;
	localparam logic [3:0] SSFM_END_8  = 4'h9;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SSFM_CLK_KHZ      = 200000;
	localparam int SSFM_PAIR_SEP_MS  = 200;
	localparam int SSFM_LONG_MARK_MS = 1000;
	localparam int SSFM_PAIR_SEP_CYC  = SSFM_PAIR_SEP_MS * SSFM_CLK_KHZ;
	localparam int SSFM_LONG_MARK_CYC = SSFM_LONG_MARK_MS * SSFM_CLK_KHZ;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [6:0]  SSFM_CTRL_RST   = 7'h00;
	localparam logic [23:0] SSFM_BITDIV_RST = 24'h14_5855;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SSFM_IDLE = 3'b001,
		SSFM_CHK  = 3'b010,
		SSFM_CNT  = 3'b100
	} ssfm_state_e;

	typedef struct packed {
		logic [1:0] code_len;
		logic       mark_hold_en;
		logic       manual_en;
		logic       manual_mode;
		logic       reduced_sens;
		logic       timing_source_select;
	} ssfm_ctrl_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ssfm_sync_s;

	typedef struct packed {
		ssfm_state_e state;
		ssfm_ctrl_s  ctrl;
		logic [23:0] bitdiv;
		logic [23:0] timer;
		logic [3:0]  cnt;
		logic        false_start_flag;
		logic        mode_decision_flag;
		logic        regenerated_output_flop;
		logic        line_out;
		logic        prev;
		logic        ext_prev;
		logic        ext_half;
		logic [1:0]  rest_cnt;
		logic        pend;
		logic [27:0] pair_cnt;
		logic [27:0] long_cnt;
		logic [31:0] prdata;
		logic        pslverr;
	} ssfm_core_s;

endpackage

// [core/ssfm_sync3.sv]
// three-stage input synchroniser that accepts a change once stages two and three agree
module ssfm_sync3
	import ssfm_pkg::*;
#(
	parameter logic RST_LVL = 1'b1
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);

	ssfm_sync_s st;
	ssfm_sync_s next_st;

	always_comb
	begin
		next_st     = st;
		next_st.s1  = din;
		next_st.s2  = st.s1;
		next_st.s3  = st.s2;
		if (st.s2 == st.s3)
		begin
			next_st.lvl = st.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '{s1: RST_LVL, s2: RST_LVL, s3: RST_LVL, lvl: RST_LVL};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign dout = st.lvl;

endmodule

// [core/ssfm_core.sv]
// start-stop character framing and automatic mode control with apb registers
//
// Summary of operation
// - start edge in stop interval zeroes timer
// - false-start flag set with timer zeroing
// - counter reset only if Space mid-start
// - Mark mid-start: noise, no count begins
// - four-bit counter counts bit intervals
// - five, seven or eight level lengths
// - character end stops counting, arms restart
// - mark-hold forces Mark in stop interval of start-stop mode
// - mark-hold off: output follows regenerated data
// - Space at character end selects synchronous
// - edge outside quarter-bit window selects start-stop
// - reduced sensitivity needs two spaced edges
// - one second Mark forces start-stop
// - consecutive rest Marks force start-stop
// - manual mode holds flag, disables long-Mark
module ssfm_core
	import ssfm_pkg::*;
#(
	parameter logic [27:0] PAIR_SEP_CYCLES  = 28'(SSFM_PAIR_SEP_CYC),
	parameter logic [27:0] LONG_MARK_CYCLES = 28'(SSFM_LONG_MARK_CYC)
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        line_in,
	input  wire logic        ext_timing,
	output logic             line_out,
	output logic             mode_sync
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] char_end_cnt(input logic [1:0] code);
		case (code)
			SSFM_CODE_7: char_end_cnt = SSFM_END_7;
			SSFM_CODE_8: char_end_cnt = SSFM_END_8;
			default:     char_end_cnt = SSFM_END_5;
		endcase
	endfunction

	ssfm_core_s  st;
	ssfm_core_s  next_st;
	logic        line;
	logic        ext_lvl;
	logic        step;
	logic        mid;
	logic        ms_edge;
	logic        start_ev;
	logic        win;
	logic        oow;
	logic        at_end;
	logic [23:0] half;
	logic [23:0] quarter;
	logic        apb_setup;
	logic        apb_wr;
	logic        addr_ok;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	ssfm_sync3 #(.RST_LVL(1'b1)) u_line_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     (line_in),
		.dout    (line)
	);

	ssfm_sync3 #(.RST_LVL(1'b0)) u_ext_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     (ext_timing),
		.dout    (ext_lvl)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// one divide stage
	assign step     = st.ctrl.timing_source_select ? (ext_lvl && !st.ext_prev && st.ext_half)
	                                               : 1'b1;
	assign half     = {1'b0, st.bitdiv[23:1]};
	assign quarter  = {2'b00, st.bitdiv[23:2]};
	assign mid      = step && (st.timer == half);
	assign ms_edge  = st.prev && !line;
	assign start_ev = ms_edge && (st.state == SSFM_IDLE);
	assign win      = (st.timer < quarter) || (st.timer >= 24'(st.bitdiv - quarter));
	assign oow      = st.mode_decision_flag && !st.ctrl.manual_en && ms_edge && !win;
	assign at_end   = (st.state == SSFM_CNT) && mid
	                  && (24'(st.cnt) + 24'h00_0001 == 24'(char_end_cnt(st.ctrl.code_len)));
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign addr_ok   = (paddr == SSFM_ADDR_CTRL) || (paddr == SSFM_ADDR_BITDIV)
	                   || (paddr == SSFM_ADDR_STATUS);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st          = st;
		next_st.prev     = line;
		next_st.ext_prev = ext_lvl;
		if (ext_lvl && !st.ext_prev)
		begin
			next_st.ext_half = !st.ext_half;
		end

		// bit timer
		if (step)
		begin
			next_st.timer = (st.timer >= 24'(st.bitdiv - 24'h00_0001)) ? 24'h00_0000
			                : 24'(st.timer + 24'h00_0001);
		end
		if (mid)
		begin
			next_st.regenerated_output_flop = line;
		end

		// framing
		case (st.state)
			SSFM_IDLE:
			begin
				if (start_ev)
				begin
					next_st.timer = 24'h00_0000;
					next_st.false_start_flag = 1'b1;
					next_st.state = SSFM_CHK;
				end
			end
			SSFM_CHK:
			begin
				if (mid)
				begin
					if (!line)
					begin
						next_st.cnt   = 4'h0;
						next_st.false_start_flag = 1'b0;
						next_st.state = SSFM_CNT;
					end
					else
					begin
						next_st.state = SSFM_IDLE;
					end
				end
			end
			SSFM_CNT:
			begin
				// count bit intervals
				// no step at the end point: the count freezes for the stop element
				if (mid && !at_end)
				begin
					next_st.cnt = 4'(st.cnt + 4'h1);
				end
				if (at_end)
				begin
					next_st.state = SSFM_IDLE;
				end
			end
			default:
			begin
				next_st.state = SSFM_IDLE;
			end
		endcase

		if (at_end && st.mode_decision_flag)
		begin
			next_st.rest_cnt = line ? ((st.rest_cnt == 2'h2) ? 2'h2 : 2'(st.rest_cnt + 2'h1))
			                        : 2'h0;
		end

		if (st.mode_decision_flag && !st.ctrl.manual_en && line)
		begin
			if (st.long_cnt != LONG_MARK_CYCLES)
			begin
				next_st.long_cnt = 28'(st.long_cnt + 28'h000_0001);
			end
		end
		else
		begin
			next_st.long_cnt = 28'h000_0000;
		end

		if (st.pend)
		begin
			next_st.pair_cnt = 28'(st.pair_cnt + 28'h000_0001);
			if (st.pair_cnt >= 28'(PAIR_SEP_CYCLES + PAIR_SEP_CYCLES))
			begin
				next_st.pend = 1'b0;
			end
		end
		if (oow && st.ctrl.reduced_sens && !st.pend)
		begin
			next_st.pend     = 1'b1;
			next_st.pair_cnt = 28'h000_0000;
		end

		// mode decision
		if (st.ctrl.manual_en)
		begin
			next_st.mode_decision_flag = st.ctrl.manual_mode;
			next_st.pend               = 1'b0;
		end
		else if (!st.mode_decision_flag)
		begin
			if (at_end && !line)
			begin
				next_st.mode_decision_flag = 1'b1;
				next_st.rest_cnt           = 2'h0;
			end
			next_st.pend = 1'b0;
		end
		else if ((oow && !st.ctrl.reduced_sens)
		         || (oow && st.pend && st.pair_cnt >= PAIR_SEP_CYCLES)
		         || (line && st.long_cnt == LONG_MARK_CYCLES)
		         || (at_end && line && st.rest_cnt != 2'h0))
		begin
			next_st.mode_decision_flag = 1'b0;
			next_st.pend               = 1'b0;
			next_st.rest_cnt           = 2'h0;
		end

		// output: hold wins over regenerated data only in start-stop idle
		// forced stop mark
		if (st.ctrl.mark_hold_en && !st.mode_decision_flag && st.state == SSFM_IDLE)
		begin
			next_st.line_out = 1'b1;
		end
		else
		begin
			next_st.line_out = st.regenerated_output_flop;
		end

		// apb: read data captured in setup, zero-wait access
		if (apb_setup)
		begin
			next_st.pslverr = !addr_ok;
			case (paddr)
				SSFM_ADDR_CTRL:   next_st.prdata = {25'h000_0000, st.ctrl};
				SSFM_ADDR_BITDIV: next_st.prdata = {8'h00, st.bitdiv};
				SSFM_ADDR_STATUS: next_st.prdata = {19'h0_0000, st.rest_cnt, st.state,
				                                    st.regenerated_output_flop, st.line_out,
				                                    st.cnt, st.false_start_flag,
				                                    st.mode_decision_flag};
				default:          next_st.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr && paddr == SSFM_ADDR_CTRL)
		begin
			next_st.ctrl = pwdata[6:0];
		end
		if (apb_wr && paddr == SSFM_ADDR_BITDIV)
		begin
			next_st.bitdiv = pwdata[23:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st        <= '0;
			st.state  <= SSFM_IDLE;
			st.ctrl   <= SSFM_CTRL_RST;
			st.bitdiv <= SSFM_BITDIV_RST;
			st.prev   <= 1'b1;
			st.regenerated_output_flop <= 1'b1;
			st.line_out <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prdata    = st.prdata;
	assign pslverr   = st.pslverr && psel && penable;
	assign pready    = 1'b1;
	assign line_out  = st.line_out;
	assign mode_sync = st.mode_decision_flag;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_start_seen;
		start_ev;
	endsequence

	sequence s_mid_space;
		(st.state == SSFM_CHK) && mid && !line;
	endsequence

	a_start_timer_zero: assert property (s_start_seen |=> st.timer == 24'h00_0000)
		else $error("timer not zeroed on start edge");
	a_start_flag_set: assert property (s_start_seen |=> st.false_start_flag && st.state == SSFM_CHK)
		else $error("false start flag not set");
	a_mid_space_go: assert property (s_mid_space |=> st.cnt == 4'h0 && st.state == SSFM_CNT)
		else $error("counter not reset on valid start");
	a_mid_mark_drop: assert property ((st.state == SSFM_CHK) && mid && line
		|=> st.state == SSFM_IDLE && $stable(st.cnt))
		else $error("noise started a character");
	a_cnt_advance: assert property ((st.state == SSFM_CNT) && mid && !at_end
		|=> st.cnt == 4'($past(st.cnt) + 4'h1))
		else $error("counter did not step");
	a_end_goes_idle: assert property (at_end |=> st.state == SSFM_IDLE && $stable(st.cnt))
		else $error("counter ran past character end");
	a_hold_gives_mark: assert property (st.ctrl.mark_hold_en && !st.mode_decision_flag
		&& st.state == SSFM_IDLE |=> st.line_out)
		else $error("mark hold not applied");
	a_follow_regen: assert property (!st.ctrl.mark_hold_en
		|=> st.line_out == $past(st.regenerated_output_flop))
		else $error("output does not follow regenerated data");
	a_space_to_sync: assert property (!st.ctrl.manual_en && !st.mode_decision_flag
		&& at_end && !line |=> st.mode_decision_flag)
		else $error("space at character end kept start-stop");
	a_window_exit: assert property (oow && !st.ctrl.reduced_sens |=> !st.mode_decision_flag)
		else $error("out-of-window edge kept synchronous");
	a_first_edge_held: assert property (oow && st.ctrl.reduced_sens && !st.pend
		&& st.long_cnt != LONG_MARK_CYCLES && !at_end |=> st.mode_decision_flag)
		else $error("single edge switched under reduced sensitivity");
	a_long_mark_exit: assert property (st.mode_decision_flag && !st.ctrl.manual_en && line
		&& st.long_cnt == LONG_MARK_CYCLES |=> !st.mode_decision_flag)
		else $error("long mark kept synchronous");
	a_manual_holds: assert property (st.ctrl.manual_en ##1 st.ctrl.manual_en
		|-> st.mode_decision_flag == $past(st.ctrl.manual_mode) && st.long_cnt == 28'h000_0000)
		else $error("manual mode not held");
	a_fs_clears: assert property (s_mid_space |=> !st.false_start_flag)
		else $error("false start flag not cleared");

endmodule

// [verif/ssfm_line_model.sv]
// line-side model: start-stop character sender and external time base
module ssfm_line_model
(
	input  wire logic pclk,
	output logic      line_in,
	output logic      ext_timing
);
	timeunit 1ns;
	timeprecision 1ps;

	int   bit_cyc;
	logic ph;

	initial
	begin
		line_in = 1'h1;
		ext_timing = 1'h0;
		ph = 1'h0;
		bit_cyc = 16;
	end

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	// 256 ext periods per bit at bit_cyc 1024
	always @(posedge pclk)
	begin
		ph <= ~ph;
		if (ph)
			ext_timing <= ~ext_timing;
	end

	// ----------------------------------------------------------------
	// sender
	// ----------------------------------------------------------------
	task automatic drive(input logic v, input int n);
		begin
			line_in <= v;
			repeat (n) @(posedge pclk);
		end
	endtask

	// stop element may be Space only when a scenario asks for it
	task automatic send_char(input logic [7:0] data, input int nbits, input logic stop_bit);
		begin
			drive(1'h0, bit_cyc);
			for (int i = 0; i < nbits; i++)
				drive(data[i], bit_cyc);
			drive(stop_bit, bit_cyc);
			line_in <= 1'h1;
		end
	endtask
endmodule

// [verif/ssfm_core_test.sv]
// self-checking bench for start-stop framing and mode control
module ssfm_core_test
	import ssfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [31:0] v;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        line_in;
	logic        ext_timing;
	logic        line_out;
	logic        mode_sync;
	int          n_fail;
	int          n_compared;
	int          seed;
	int          nb;

	initial pclk = 1'h0;
	always #2.5 pclk = ~pclk;

	// short counts keep the run brief
	ssfm_core #(.PAIR_SEP_CYCLES(28'h000_00C8), .LONG_MARK_CYCLES(28'h000_03E8)) ssfm_core_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_in(line_in), .ext_timing(ext_timing), .line_out(line_out), .mode_sync(mode_sync));

	ssfm_line_model ssfm_line_model_inst (.pclk(pclk), .line_in(line_in), .ext_timing(ext_timing));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task final_report;
		begin
			if (n_fail == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_compared++;
			if (seen !== exp)
			begin
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
				n_fail++;
			end
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'h1;
			k = 0;
			do
			begin
				@(posedge pclk);
				k++;
			end
			while (pready !== 1'h1 && k < 20);
			if (k >= 20)
			begin
				n_fail++;
				final_report;
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			// one idle edge so a following call never re-drives psel in this step
			@(posedge pclk);
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 90288;
		n_fail = 0;
		n_compared = 0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk(mode_sync, 32'h0000_0000);
		chk(line_out, 32'h0000_0001);
		apb(1'h0, SSFM_ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'h0, SSFM_ADDR_BITDIV, 32'h0000_0000);
		chk(rd, 32'(SSFM_BITDIV_RST));
		apb(1'h0, 8'h0C, 32'h0000_0000);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'h1, SSFM_ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'h0, SSFM_ADDR_STATUS, 32'h0000_0000);
		chk(rd[1:0], 32'h0000_0000);
		v = $random(seed);
		apb(1'h1, SSFM_ADDR_BITDIV, v);
		apb(1'h0, SSFM_ADDR_BITDIV, 32'h0000_0000);
		chk(rd, {8'h00, v[23:0]});
		apb(1'h1, SSFM_ADDR_BITDIV, 32'h0000_0010);
		for (int c = 0; c < 3; c++)
		begin
			nb = (c == 0) ? 5 : ((c == 1) ? 7 : 8);
			v = $random(seed);
			apb(1'h1, SSFM_ADDR_CTRL, {25'h000_0000, 2'(c), v[0], 4'h0});
			ssfm_line_model_inst.send_char(v[15:8], nb, 1'h1);
			// let the stop release settle before the next start edge
			@(posedge pclk);
			// all-Space data: an early end point would see Space
			fork
				ssfm_line_model_inst.send_char(8'h00, nb, 1'h1);
			join_none
			repeat (24) @(posedge pclk);
			apb(1'h0, SSFM_ADDR_STATUS, 32'h0000_0000);
			chk(rd[10:8], 32'h0000_0004);
			chk(rd[1], 32'h0000_0000);
			chk(line_out, 32'h0000_0000);
			repeat ((nb + 2) * 16) @(posedge pclk);
			chk(mode_sync, 32'h0000_0000);
			apb(1'h0, SSFM_ADDR_STATUS, 32'h0000_0000);
			chk(rd[10:8], 32'h0000_0001);
			chk(line_out, 32'h0000_0001);
			ssfm_line_model_inst.send_char(8'hFF, nb, 1'h0);
			repeat (8) @(posedge pclk);
			chk(mode_sync, 32'h0000_0001);
			repeat (1200) @(posedge pclk);
			chk(mode_sync, 32'h0000_0000);
		end
		// noise pulse shorter than half a bit
		ssfm_line_model_inst.drive(1'h0, 5);
		ssfm_line_model_inst.drive(1'h1, 2);
		apb(1'h0, SSFM_ADDR_STATUS, 32'h0000_0000);
		chk(rd[10:8], 32'h0000_0002);
		chk(rd[1], 32'h0000_0001);
		repeat (20) @(posedge pclk);
		apb(1'h0, SSFM_ADDR_STATUS, 32'h0000_0000);
		chk(rd[10:8], 32'h0000_0001);
		apb(1'h1, SSFM_ADDR_CTRL, 32'h0000_000C);
		repeat (2) @(posedge pclk);
		chk(mode_sync, 32'h0000_0001);
		repeat (1200) @(posedge pclk);
		chk(mode_sync, 32'h0000_0001);
		apb(1'h1, SSFM_ADDR_CTRL, 32'h0000_0008);
		repeat (2) @(posedge pclk);
		chk(mode_sync, 32'h0000_0000);
		// external time base: bit is 256 ext periods
		apb(1'h1, SSFM_ADDR_CTRL, 32'h0000_0001);
		apb(1'h1, SSFM_ADDR_BITDIV, 32'h0000_0080);
		ssfm_line_model_inst.bit_cyc = 1024;
		ssfm_line_model_inst.send_char(8'hFF, 5, 1'h0);
		repeat (8) @(posedge pclk);
		chk(mode_sync, 32'h0000_0001);
		final_report;
	end
endmodule
